// file: design/nvdi_pkg.sv
/*
  Constants for the nonvolatile memory divider, security and command
  index register bank: register indices, byte addresses, field
  positions, reset values and sizes.
  Assumes one bus clock domain and APB with 32-bit data.
*/
package nvdi_pkg;

  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int INDEX_W = 3;
  localparam int CMD_DEPTH = 8;
  localparam int CMD_W = 16;
  localparam int DIV_W = 6;

  // printed offsets are not all multiples of four: byte address = 4 x index
  localparam logic [15:0] IDX_CLOCK_DIVIDER = 16'h3020;
  localparam logic [15:0] IDX_SECURITY_STATE = 16'h3021;
  localparam logic [15:0] IDX_COMMAND_INDEX = 16'h3022;
  localparam logic [15:0] IDX_CMD_OBJECT_HI = 16'h302A;
  localparam logic [15:0] IDX_CMD_OBJECT_LO = 16'h302B;

  localparam logic [ADDR_W-1:0] ADDR_CLOCK_DIVIDER =
    {IDX_CLOCK_DIVIDER, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_SECURITY_STATE =
    {IDX_SECURITY_STATE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_COMMAND_INDEX =
    {IDX_COMMAND_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CMD_OBJECT_HI =
    {IDX_CMD_OBJECT_HI, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CMD_OBJECT_LO =
    {IDX_CMD_OBJECT_LO, 2'b00};

  // clock divider fields
  localparam int DIV_LOADED_BIT = 7;
  localparam int DIV_LOCK_BIT = 6;
  localparam int DIV_VALUE_MSB = 5;
  localparam logic [7:0] CLOCK_DIVIDER_RESET = 8'h00;

  // security fields
  localparam int KEY_EN_MSB = 7;
  localparam int KEY_EN_LSB = 6;
  localparam int SEC_STATE_MSB = 1;
  localparam int SEC_STATE_LSB = 0;
  localparam logic [1:0] KEY_ENABLED_PAT = 2'h2;
  localparam logic [1:0] SEC_UNSECURED_PAT = 2'h2;
  localparam logic [7:0] SECURITY_RESET = 8'h00;
  localparam logic [15:0] SEC_CFG_ADDR = 16'hFF7F;

  localparam logic [7:0] COMMAND_INDEX_RESET = 8'h00;
  localparam logic [CMD_W-1:0] CMD_WORD_RESET = 16'h0000;

  typedef enum logic [1:0]
  {
    LD_REQ = 2'b00,
    LD_WAIT = 2'b01,
    LD_DONE = 2'b11
  } nvdi_load_state_t;

endpackage

// file: design/nvdi_sec_loader.sv
/*
  Security register: filled once after reset from the flash
  configuration byte, forced unsecured on a backdoor unlock.
  Assumes the flash read port answers on the same clock.
*/
module nvdi_sec_loader
(
  input wire logic i_clk, // bus clock
  input wire logic i_reset_n, // async reset, active low
  output logic o_rd_req, // read request to flash, high through reset and for one cycle after it
  output logic [15:0] o_rd_addr, // flash address of the config byte
  input wire logic i_rd_valid, // flash read data valid
  input wire logic [7:0] i_rd_data, // flash read data
  input wire logic i_backdoor_unlock, // pulse: backdoor key accepted
  output logic [7:0] o_sec_q, // security register content
  output logic o_ready // security register loaded
);
  import nvdi_pkg::*;

  nvdi_load_state_t state_q;
  logic unlocked_q;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      state_q <= LD_REQ;
    else
      case (state_q)
        LD_REQ: state_q <= LD_WAIT;
        LD_WAIT: if (i_rd_valid) state_q <= LD_DONE;
        LD_DONE: state_q <= LD_DONE;
        default: state_q <= LD_REQ;
      endcase
  end

  // remembered so a late load cannot undo an unlock
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      unlocked_q <= 1'b0;
    else if (i_backdoor_unlock)
      unlocked_q <= 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_sec_q <= SECURITY_RESET;
    else if (state_q == LD_WAIT && i_rd_valid)
    begin
      o_sec_q <= i_rd_data;
      if (unlocked_q || i_backdoor_unlock)
        o_sec_q[SEC_STATE_MSB:SEC_STATE_LSB] <= SEC_UNSECURED_PAT;
    end
    else if (i_backdoor_unlock)
      o_sec_q[SEC_STATE_MSB:SEC_STATE_LSB] <= SEC_UNSECURED_PAT;
  end

  assign o_rd_req = (state_q == LD_REQ);
  assign o_rd_addr = SEC_CFG_ADDR;
  assign o_ready = (state_q == LD_DONE);

endmodule

// file: design/nvdi_cmd_array.sv
/*
  Command object array: indexed words, written a byte at a time
  from the bus, read by the command sequencer.
  Assumes index and strobes come from the same clock.
*/
module nvdi_cmd_array
#(
  parameter int DEPTH = 8,
  parameter int IW = 3
)
(
  input wire logic i_clk, // bus clock
  input wire logic i_reset_n, // async reset, active low
  input wire logic [IW-1:0] i_index, // word selected by software
  input wire logic i_wr_hi, // write strobe, high byte
  input wire logic i_wr_lo, // write strobe, low byte
  input wire logic [7:0] i_wdata, // byte to write
  output logic [15:0] o_word, // selected word, combinational
  input wire logic [IW-1:0] i_seq_index, // sequencer word select
  output logic [15:0] o_seq_word // sequencer word, registered
);
  import nvdi_pkg::*;

  logic [15:0] mem_q [DEPTH];

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= CMD_WORD_RESET;
    end
    else
    begin
      if (i_wr_hi)
        mem_q[i_index][15:8] <= i_wdata;
      if (i_wr_lo)
        mem_q[i_index][7:0] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_seq_word <= CMD_WORD_RESET;
    else
      o_seq_word <= mem_q[i_seq_index];
  end

  assign o_word = mem_q[i_index];

endmodule

// file: design/nvdi_regs.sv
/*
  Register bank of the nonvolatile memory controller: timing
  divider with loaded flag and write-once lock, read-only security
  register, command index and the command object ports, over APB.
  Assumes an APB master on i_clk; the flash byte read and the
  backdoor unlock come from logic on the same clock.
*/
// Implementation choice: the APB interface to the registers.
//
// Contract
// - The loaded flag reads 0 until the first divider write, then 1.
// - A set lock freezes the divider value until reset.
// - The security register is read-only; writes change nothing.
// - The security register loads from flash byte 0xFF7F after reset.
// - Backdoor access is enabled only by key pattern 10.
// - The device is unsecured only for security pattern 10.
// - A backdoor unlock forces the security state to 10.
// - Command index bits 7 to 3 read as zero.
// - The command index picks the command object word accessed.
// - The divider register is 8 bits and resets to 00h.
module nvdi_regs
(
  input wire logic i_clk, // bus clock
  input wire logic i_reset_n, // async reset, active low
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb direction, 1 = write
  input wire logic [nvdi_pkg::ADDR_W-1:0] i_paddr, // apb byte address
  input wire logic [nvdi_pkg::DATA_W-1:0] i_pwdata, // apb write data
  output logic [nvdi_pkg::DATA_W-1:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error, unmapped
  output logic [nvdi_pkg::DIV_W-1:0] o_divider_value, // divider value
  output logic o_divider_loaded_flag, // divider written since reset
  output logic o_divider_lock, // divider frozen
  output logic o_timing_tick, // pulse per divided period
  output logic o_backdoor_key_enable, // backdoor access allowed
  output logic o_secured, // device secured
  output logic o_sec_rd_req, // read security byte, high through reset and for one cycle after it
  output logic [15:0] o_sec_rd_addr, // flash address of that byte
  input wire logic i_sec_rd_valid, // security byte valid
  input wire logic [7:0] i_sec_rd_data, // security byte
  input wire logic i_backdoor_unlock, // pulse: backdoor key accepted
  input wire logic [nvdi_pkg::INDEX_W-1:0] i_seq_index, // seq word select
  output logic [15:0] o_seq_word // seq command word
);
  import nvdi_pkg::*;

  logic [7:0] clock_divider_read;
  logic divider_loaded_flag_q;
  logic divider_lock_q;
  logic [DIV_W-1:0] divider_value_q;
  logic [INDEX_W-1:0] command_word_index_q;
  logic [DIV_W-1:0] tick_count_q;
  logic [7:0] sec_q;
  logic sec_ready;
  logic [15:0] cmd_word;
  logic setup;
  logic access;
  logic wr_en;
  logic hit;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;
  logic [7:0] index_read;
  logic ready_q;
  logic wr_divider;
  logic wr_index;
  logic wr_cmd_hi;
  logic wr_cmd_lo;

  assign setup = i_psel && !i_penable;
  assign access = i_psel && i_penable;
  // bus held off until the security byte is in; one cycle more so a
  // read stalled across the load captures the loaded byte
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      ready_q <= 1'b0;
    else
      ready_q <= sec_ready;
  end

  assign o_pready = ready_q;
  assign wr_en = access && o_pready && i_pwrite;
  assign wbyte = i_pwdata[7:0];
  assign wr_divider = wr_en && (i_paddr == ADDR_CLOCK_DIVIDER);
  assign wr_index = wr_en && (i_paddr == ADDR_COMMAND_INDEX);
  assign wr_cmd_hi = wr_en && (i_paddr == ADDR_CMD_OBJECT_HI);
  assign wr_cmd_lo = wr_en && (i_paddr == ADDR_CMD_OBJECT_LO);

  // decode
  always_comb
  begin
    hit = 1'b1;
    rd_byte = 8'h00;
    case (i_paddr)
      ADDR_CLOCK_DIVIDER: rd_byte = clock_divider_read;
      ADDR_SECURITY_STATE: rd_byte = sec_q;
      ADDR_COMMAND_INDEX: rd_byte = index_read;
      ADDR_CMD_OBJECT_HI: rd_byte = cmd_word[15:8];
      ADDR_CMD_OBJECT_LO: rd_byte = cmd_word[7:0];
      default: hit = 1'b0;
    endcase
  end

  assign index_read = {{(8 - INDEX_W){1'b0}}, command_word_index_q};

  // captured in setup and again while stalled, then held to the end
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_prdata <= 32'h0000_0000;
    else if (setup || (access && !o_pready))
      o_prdata <= {24'h00_0000, rd_byte};
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_pslverr <= 1'b0;
    else if (setup || (access && !o_pready))
      o_pslverr <= !hit;
    else if (!i_psel)
      o_pslverr <= 1'b0;
  end

  // timing divider register, one flop group per field
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      divider_loaded_flag_q <= CLOCK_DIVIDER_RESET[DIV_LOADED_BIT];
    else if (wr_divider)
      divider_loaded_flag_q <= 1'b1;
  end

  // write-once: only reset reopens the lock and the value
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      divider_lock_q <= CLOCK_DIVIDER_RESET[DIV_LOCK_BIT];
    else if (wr_divider && !divider_lock_q)
      divider_lock_q <= wbyte[DIV_LOCK_BIT];
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      divider_value_q <= CLOCK_DIVIDER_RESET[DIV_VALUE_MSB:0];
    else if (wr_divider && !divider_lock_q)
      divider_value_q <= wbyte[DIV_VALUE_MSB:0];
  end

  always_comb
  begin
    clock_divider_read = CLOCK_DIVIDER_RESET;
    clock_divider_read[DIV_LOADED_BIT] = divider_loaded_flag_q;
    clock_divider_read[DIV_LOCK_BIT] = divider_lock_q;
    clock_divider_read[DIV_VALUE_MSB:0] = divider_value_q;
  end

  assign o_divider_value = divider_value_q;
  assign o_divider_loaded_flag = divider_loaded_flag_q;
  assign o_divider_lock = divider_lock_q;

  // divide by value + 1; idle until software has loaded a divider
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      tick_count_q <= '0;
    else if (!o_divider_loaded_flag || tick_count_q >= o_divider_value)
      tick_count_q <= '0;
    else
      tick_count_q <= tick_count_q + 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_timing_tick <= 1'b0;
    else
      o_timing_tick <= o_divider_loaded_flag &&
                       tick_count_q >= o_divider_value;
  end

  // command index register; upper bits are not stored
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      command_word_index_q <= COMMAND_INDEX_RESET[INDEX_W-1:0];
    else if (wr_index)
      command_word_index_q <= wbyte[INDEX_W-1:0];
  end

  // no write path reaches sec_q
  nvdi_sec_loader u_sec
  (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .o_rd_req(o_sec_rd_req),
    .o_rd_addr(o_sec_rd_addr),
    .i_rd_valid(i_sec_rd_valid),
    .i_rd_data(i_sec_rd_data),
    .i_backdoor_unlock(i_backdoor_unlock),
    .o_sec_q(sec_q),
    .o_ready(sec_ready)
  );

  assign o_backdoor_key_enable =
    (sec_q[KEY_EN_MSB:KEY_EN_LSB] == KEY_ENABLED_PAT);
  assign o_secured =
    (sec_q[SEC_STATE_MSB:SEC_STATE_LSB] != SEC_UNSECURED_PAT);

  nvdi_cmd_array
  #(
    .DEPTH(CMD_DEPTH),
    .IW(INDEX_W)
  )
  u_cmd
  (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_index(command_word_index_q),
    .i_wr_hi(wr_cmd_hi),
    .i_wr_lo(wr_cmd_lo),
    .i_wdata(wbyte),
    .o_word(cmd_word),
    .i_seq_index(i_seq_index),
    .o_seq_word(o_seq_word)
  );

endmodule

// file: test/nvdi_regs_checker.sv
/*
  Port checker for nvdi_regs: divider flag and lock, security
  decode and unlock, command index read-back.
  Assumes an APB master on i_clk; bound to every nvdi_regs.
*/
module nvdi_regs_checker
(
  input wire logic i_clk, // bus clock
  input wire logic i_reset_n, // async reset, active low
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb direction
  input wire logic [nvdi_pkg::ADDR_W-1:0] i_paddr, // apb address
  input wire logic [nvdi_pkg::DATA_W-1:0] i_pwdata, // apb write data
  input wire logic [nvdi_pkg::DATA_W-1:0] o_prdata, // apb read data
  input wire logic o_pready, // apb ready
  input wire logic [nvdi_pkg::DIV_W-1:0] o_divider_value, // divider
  input wire logic o_divider_loaded_flag, // loaded flag
  input wire logic o_divider_lock, // lock
  input wire logic o_backdoor_key_enable, // key enable
  input wire logic o_secured, // secured
  input wire logic i_backdoor_unlock // unlock pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  import nvdi_pkg::*;
  logic acc;
  logic div_wr;
  assign acc = i_psel && i_penable && o_pready;
  assign div_wr = acc && i_pwrite && i_paddr == ADDR_CLOCK_DIVIDER;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  sequence s_open_wr;
    div_wr && !o_divider_lock;
  endsequence
  sequence s_locked_wr;
    div_wr && o_divider_lock;
  endsequence
  sequence s_rd_sec;
    acc && !i_pwrite && i_paddr == ADDR_SECURITY_STATE;
  endsequence
  sequence s_rd_idx;
    acc && !i_pwrite && i_paddr == ADDR_COMMAND_INDEX;
  endsequence
  AST_FLAG_SET: assert property (div_wr |=> o_divider_loaded_flag)
    else $error("loaded flag not set by divider write");
  AST_FLAG_HOLD: assert property (
    o_divider_loaded_flag |=> o_divider_loaded_flag [*2])
    else $error("loaded flag dropped without reset");
  AST_DIV_WRITE: assert property (s_open_wr |=>
    o_divider_value == $past(i_pwdata[DIV_VALUE_MSB:0]) &&
    o_divider_lock == $past(i_pwdata[DIV_LOCK_BIT]))
    else $error("open divider write not taken");
  AST_LOCK_FREEZE: assert property (s_locked_wr |=>
    $stable(o_divider_value) && o_divider_lock)
    else $error("locked divider changed");
  AST_KEY_DECODE: assert property (s_rd_sec |->
    o_backdoor_key_enable ==
    (o_prdata[KEY_EN_MSB:KEY_EN_LSB] == KEY_ENABLED_PAT))
    else $error("key enable decode wrong");
  AST_SEC_DECODE: assert property (s_rd_sec |->
    o_secured ==
    (o_prdata[SEC_STATE_MSB:SEC_STATE_LSB] != SEC_UNSECURED_PAT))
    else $error("secured decode wrong");
  AST_UNLOCK: assert property (
    i_backdoor_unlock |=> !o_secured ##1 !o_secured)
    else $error("unlock did not clear secured");
  AST_IDX_ZERO: assert property (
    s_rd_idx |-> o_prdata[31:INDEX_W] == '0)
    else $error("index upper bits not zero");
endmodule

bind nvdi_regs nvdi_regs_checker chk_u (.*);

// file: test/tb_nvdi_regs.sv
/*
  Self-checking bench for nvdi_regs: APB tasks, security load per
  pattern, divider lock, unlock, index and command words, unmapped.
  Assumes the checker file is compiled alongside.
*/
module tb_nvdi_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import nvdi_pkg::*;
  logic i_clk, i_reset_n, i_psel, i_penable, i_pwrite;
  logic [ADDR_W-1:0] i_paddr;
  logic [DATA_W-1:0] i_pwdata, o_prdata, rd;
  logic o_pready, o_pslverr, o_divider_loaded_flag, o_divider_lock, err;
  logic o_timing_tick, o_backdoor_key_enable, o_secured, o_sec_rd_req;
  logic i_sec_rd_valid, i_backdoor_unlock;
  logic [DIV_W-1:0] o_divider_value;
  logic [15:0] o_sec_rd_addr, o_seq_word;
  logic [7:0] i_sec_rd_data, sb;
  logic [INDEX_W-1:0] i_seq_index;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  int ticks = 0;

  nvdi_regs dut_u (.*);

  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, exp, input string name);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // request held until pready is sampled high, then one idle edge
  task automatic apb(input logic w, input logic [17:0] a,
    input logic [31:0] d);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic boot(input logic [7:0] b);
    i_reset_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    chk(o_sec_rd_req, 1, "sec_rd_req");
    chk(o_sec_rd_addr, SEC_CFG_ADDR, "sec_rd_addr");
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk(o_sec_rd_req, 0, "sec_rd_req_low");
    chk(o_pready, 0, "pready_before_load");
    chk(o_divider_loaded_flag, 0, "loaded_after_reset");
    chk(o_divider_lock, 0, "lock_after_reset");
    chk(o_timing_tick, 0, "tick_before_load");
    i_sec_rd_valid <= 1'b1;
    i_sec_rd_data <= b;
    @(posedge i_clk);
    i_sec_rd_valid <= 1'b0;
    i_sec_rd_data <= ~b; // released byte is not left on the bus
    @(posedge i_clk);
  endtask

  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      error_cnt++;
      give_verdict();
    end
  end

  initial
  begin
    {i_reset_n, i_psel, i_penable, i_pwrite, i_sec_rd_valid} = '0;
    {i_paddr, i_pwdata, i_sec_rd_data, i_seq_index} = '0;
    i_backdoor_unlock = 1'b0;
    @(posedge i_clk);
    for (int p = 0; p < 4; p++)
    begin
      sb = {p[1:0], 4'h0, p[1:0]};
      boot(sb);
      chk(o_backdoor_key_enable, p == 2, "key_enable");
      chk(o_secured, p != 2, "secured");
      apb(1'b1, ADDR_SECURITY_STATE, 32'hFFFF_FFFF);
      apb(1'b0, ADDR_SECURITY_STATE, 32'h0000_0000);
      chk(rd, sb, "security");
      chk(err, 0, "security_no_error");
    end
    $display("test done: security load");
    apb(1'b0, ADDR_CLOCK_DIVIDER, 32'h0000_0000);
    chk(rd, CLOCK_DIVIDER_RESET, "divider_reset");
    apb(1'b1, ADDR_CLOCK_DIVIDER, 32'h0000_0005);
    apb(1'b0, ADDR_CLOCK_DIVIDER, 32'h0000_0000);
    chk(rd, 32'h0000_0085, "divider_open");
    chk(o_divider_loaded_flag, 1, "loaded_pin");
    apb(1'b1, ADDR_CLOCK_DIVIDER, 32'h0000_004A);
    apb(1'b1, ADDR_CLOCK_DIVIDER, 32'h0000_0003);
    apb(1'b0, ADDR_CLOCK_DIVIDER, 32'h0000_0000);
    chk(rd, 32'h0000_00CA, "divider_frozen");
    chk(o_divider_value, 6'h0A, "divider_value");
    chk(o_divider_lock, 1, "lock_pin");
    chk(o_divider_loaded_flag, 1, "loaded_after_locked");
    // divider 0x0A divides by value + 1, so a tick every 11 cycles
    do @(posedge i_clk); while (o_timing_tick !== 1'b1);
    ticks = 0;
    do
    begin
      @(posedge i_clk);
      ticks++;
    end
    while (o_timing_tick !== 1'b1);
    chk(ticks, 32'd11, "tick_period");
    $display("test done: divider");
    i_backdoor_unlock <= 1'b1;
    @(posedge i_clk);
    i_backdoor_unlock <= 1'b0;
    @(posedge i_clk);
    chk(o_secured, 0, "unlocked");
    apb(1'b0, ADDR_SECURITY_STATE, 32'h0000_0000);
    chk(rd, 32'h0000_00C2, "security_unlocked");
    $display("test done: unlock");
    apb(1'b1, ADDR_COMMAND_INDEX, 32'h0000_00FF);
    apb(1'b0, ADDR_COMMAND_INDEX, 32'h0000_0000);
    chk(rd, 32'h0000_0007, "index_upper");
    apb(1'b1, ADDR_COMMAND_INDEX, 32'h0000_0003);
    apb(1'b1, ADDR_CMD_OBJECT_HI, 32'h0000_00AB);
    apb(1'b1, ADDR_CMD_OBJECT_LO, 32'h0000_00CD);
    apb(1'b0, ADDR_CMD_OBJECT_HI, 32'h0000_0000);
    chk(rd, 32'h0000_00AB, "cmd_hi");
    i_seq_index <= 3'h3;
    repeat (2) @(posedge i_clk);
    chk(o_seq_word, 16'hABCD, "seq_word");
    apb(1'b1, ADDR_COMMAND_INDEX, 32'h0000_0000);
    apb(1'b0, ADDR_CMD_OBJECT_LO, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "cmd_lo_word0");
    $display("test done: command index");
    apb(1'b0, 18'h0_C090, 32'h0000_0000);
    chk(err, 1, "unmapped_error");
    chk(rd, 32'h0000_0000, "unmapped_data");
    $display("test done: unmapped");
    give_verdict();
  end
endmodule
